// ===== src/urxf_pkg.sv
// Package for the UART receive framing, multidrop and command block.
// Assumes one 100 MHz clock domain; shared by the block and its bench.
package urxf_pkg;
	localparam int CLK_MHZ = 100;
	localparam int OVS = 16;
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] SAMPLE_A = 4'h6;
	localparam logic [3:0] SAMPLE_B = 4'h7;
	localparam logic [3:0] SAMPLE_C = 4'h8;
	localparam logic [3:0] BITS_MODE2 = 4'h9;
	localparam logic [7:0] CMD_ENABLE = 8'hFE;
	localparam logic [7:0] CMD_SOFT_POR = 8'hFE;
	localparam logic [7:0] CMD_PROGRAM = 8'hFD;
	localparam logic [1:0] MODE_1 = 2'h1;
	localparam logic [1:0] MODE_2 = 2'h2;
	localparam logic [1:0] MODE_3 = 2'h3;
	localparam logic RST_MODE_LOW = 1'b0;
	localparam logic RST_FAULT = 1'b0;
	localparam logic [7:0] RST_BYTE = 8'h00;

	typedef enum logic [2:0] {
		URXF_IDLE = 3'h0,
		URXF_START = 3'h1,
		URXF_DATA = 3'h2,
		URXF_STOP = 3'h3
	} urxf_rx_state_t;

	typedef enum logic [2:0] {
		URXF_C_WAIT_BRK1 = 3'h0,
		URXF_C_WAIT_FE = 3'h1,
		URXF_C_WAIT_BRK2 = 3'h2,
		URXF_C_WAIT_CMD = 3'h3,
		URXF_C_WAIT_QUIET = 3'h4
	} urxf_cmd_state_t;
endpackage

// ===== src/urxf_rx.sv
// UART receive side: modes 2/3 framing, fault flag, multidrop, irq pending, commands.
// Assumes i_baud16 is a one-cycle tick at 16x bit rate from an outside generator.
//
// Behaviour
// - Mode 3 receives exactly like mode 2.
// - Missing stop bit sets framing fault flag.
// - Fault flag sticky until software clear or reset.
// - Shared bit selects mode bit or fault.
// - Multidrop: ninth bit one marks address.
// - Multidrop interrupts only on matching address.
// - Hold 8-bit station address.
// - Mask zero bits are don't-care.
// - Also match broadcast address OR of both.
// - Mask bits enable receive/transmit interrupts.
// - Pending equals done flag AND mask.
// - Clearing done flag withdraws pending.
// - Command after break, FEh, break, command.
// - Other traffic in sequence cancels command.
// - Exactly two fixed reserved commands.
// - Command FEh triggers full chip reset.
// - Command FDh starts serial programming.
// - Multidrop loads only ninth-bit-one, done clear.
`timescale 1ns/1ps
module urxf_rx
	import urxf_pkg::*;
(
	input wire logic i_mclk, // System clock
	input wire logic i_nrst, // Async reset, active low
	input wire logic i_rxd, // Serial receive pin
	input wire logic i_baud16, // 16x sampling tick
	input wire logic i_rx_enable, // Receive enable
	input wire logic i_mode_high, // Upper mode bit
	input wire logic i_multidrop_enable, // Multidrop enable
	input wire logic i_framing_flag_select, // 1 selects fault flag at shared bit
	input wire logic i_shared_wr, // Write strobe for shared bit
	input wire logic i_shared_wdata, // Value written to shared bit
	input wire logic [7:0] i_station_address, // Station address
	input wire logic [7:0] i_station_address_mask, // Station address mask
	input wire logic i_receive_irq_mask, // Receive interrupt mask
	input wire logic i_transmit_irq_mask, // Transmit interrupt mask
	input wire logic i_rx_done_clr, // Software writes receive done to zero
	input wire logic i_tx_done_set, // Transmitter finished a word
	input wire logic i_tx_done_clr, // Software writes transmit done to zero
	output logic o_shared_rdata, // Shared bit read value
	output logic o_mode_select_low, // Lower mode bit
	output logic o_framing_fault_flag, // Sticky framing fault
	output logic [7:0] o_rx_data, // Received byte buffer
	output logic o_rx_bit9, // Received ninth bit
	output logic o_receive_done_flag, // Receive done flag
	output logic o_transmit_done_flag, // Transmit done flag
	output logic o_receive_irq_pending, // Receive pending
	output logic o_transmit_irq_pending, // Transmit pending
	output logic o_irq, // Interrupt request
	output logic o_soft_por, // Soft reset pulse
	output logic o_program_req // Program loading pulse
);
	import urxf_pkg::*;

	logic rxd_meta_reg, rxd_sync_reg;
	urxf_rx_state_t state_reg, state_next;
	urxf_cmd_state_t cmd_reg, cmd_next;
	logic [3:0] tick_reg, bit_cnt_reg;
	logic [2:0] votes_reg;
	logic [8:0] shift_reg;
	logic mode_low_reg, fault_reg, rx_done_reg, tx_done_reg;
	logic [7:0] data_reg;
	logic bit9_reg, por_reg, prog_reg;

	function automatic logic majority(input logic [2:0] v);
		majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	// Unmasked bits must agree; a zero care bit is a don't-care
	function automatic logic masked_equal(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] care);
		masked_equal = ((a ^ b) & care) == 8'h00;
	endfunction

	wire logic mode_nine = i_mode_high; // modes 2 and 3 share one frame
	wire logic tick_end = i_baud16 && (tick_reg == OVS_LAST);
	wire logic at_vote = i_baud16 && (tick_reg == SAMPLE_C);
	wire logic at_sample = i_baud16 && (tick_reg == SAMPLE_A || tick_reg == SAMPLE_B);
	// Two stored samples of this bit plus the live third one
	wire logic bit_val = majority({votes_reg[1:0], rxd_sync_reg});
	wire logic fault_sel = i_framing_flag_select;
	wire logic [7:0] care_bits = i_station_address_mask;
	wire logic [7:0] bcast = i_station_address | i_station_address_mask;
	wire logic ninth_end = at_vote && (state_reg == URXF_DATA) && (bit_cnt_reg == BITS_MODE2)
		&& mode_nine;
	wire logic stop_end = at_vote && (state_reg == URXF_STOP);
	// Ninth vote: shift register plus the live bit is the whole word
	wire logic [8:0] word_now = {bit_val, shift_reg[8:1]};
	wire logic word_addr = i_multidrop_enable && word_now[8];
	wire logic given_hit = masked_equal(word_now[7:0], i_station_address, care_bits);
	wire logic bcast_hit = masked_equal(word_now[7:0], bcast, bcast);
	wire logic word_match = given_hit || bcast_hit;
	// data words skipped in multidrop mode
	wire logic load_ok = !rx_done_reg && (!i_multidrop_enable || (word_addr && word_match));
	wire logic do_load = ninth_end && load_ok;
	wire logic frame_bad = stop_end && !bit_val;
	wire logic frame_good = stop_end && bit_val;
	// A break: all nine bits low and the stop bit low as well
	wire logic brk = frame_bad && (shift_reg == 9'h000);
	wire logic tick_clr = tick_end || (at_vote && state_reg == URXF_STOP);
	wire logic [3:0] tick_next = tick_clr ? 4'h0 : tick_reg + 4'h1;

	assign o_shared_rdata = fault_sel ? fault_reg : mode_low_reg;
	assign o_mode_select_low = mode_low_reg;
	assign o_framing_fault_flag = fault_reg;
	assign o_rx_data = data_reg;
	assign o_rx_bit9 = bit9_reg;
	assign o_receive_done_flag = rx_done_reg;
	assign o_transmit_done_flag = tx_done_reg;
	assign o_receive_irq_pending = rx_done_reg & i_receive_irq_mask;
	assign o_transmit_irq_pending = tx_done_reg & i_transmit_irq_mask;
	assign o_irq = o_receive_irq_pending | o_transmit_irq_pending;
	assign o_soft_por = por_reg;
	assign o_program_req = prog_reg;

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			rxd_meta_reg <= 1'b1;
			rxd_sync_reg <= 1'b1;
		end else begin
			rxd_meta_reg <= i_rxd;
			rxd_sync_reg <= rxd_meta_reg;
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			URXF_IDLE: begin
				if (i_rx_enable && mode_nine && !rxd_sync_reg)
					state_next = URXF_START;
			end
			URXF_START: begin
				if (at_vote)
					state_next = bit_val ? URXF_IDLE : URXF_DATA;
			end
			URXF_DATA: begin
				if (ninth_end)
					state_next = URXF_STOP;
			end
			URXF_STOP: begin
				// Back to hunting at mid stop bit, as the receiver must resync
				if (stop_end)
					state_next = URXF_IDLE;
			end
			default: state_next = URXF_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= URXF_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Counter parks at zero while hunting so each frame starts aligned
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			tick_reg <= 4'h0;
		end else if (state_reg == URXF_IDLE) begin
			tick_reg <= 4'h0;
		end else if (i_baud16) begin
			tick_reg <= tick_next;
		end
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			votes_reg <= 3'h0;
		end else if (at_sample) begin
			votes_reg <= {votes_reg[1:0], rxd_sync_reg};
		end
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			bit_cnt_reg <= 4'h0;
		end else if (state_reg == URXF_START) begin
			bit_cnt_reg <= 4'h1;
		end else if (at_vote && state_reg == URXF_DATA) begin
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
		end
	end

	// LSB arrives first, so bits enter at the top and move down
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			shift_reg <= 9'h000;
		end else if (at_vote && state_reg == URXF_DATA) begin
			shift_reg <= word_now;
		end
	end

	// Same bit position, separate storage from the fault flag
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			mode_low_reg <= RST_MODE_LOW;
		end else if (i_shared_wr && !fault_sel) begin
			mode_low_reg <= i_shared_wdata;
		end
	end

	// Set wins over a same-cycle clear; good frames never clear
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			fault_reg <= RST_FAULT;
		end else if (frame_bad) begin
			fault_reg <= 1'b1;
		end else if (i_shared_wr && fault_sel) begin
			fault_reg <= i_shared_wdata;
		end
	end

	// A word landing as software clears is dropped: done is still set, so the clear wins
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			rx_done_reg <= 1'b0;
		end else if (do_load) begin
			rx_done_reg <= 1'b1;
		end else if (i_rx_done_clr) begin
			rx_done_reg <= 1'b0;
		end
	end

	// Only the flag lives here; the transmit shifter is elsewhere
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			tx_done_reg <= 1'b0;
		end else if (i_tx_done_set) begin
			tx_done_reg <= 1'b1;
		end else if (i_tx_done_clr) begin
			tx_done_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			data_reg <= RST_BYTE;
			bit9_reg <= 1'b0;
		end else if (do_load) begin
			data_reg <= word_now[7:0];
			bit9_reg <= word_now[8];
		end
	end

	// Command recogniser: a break is an all-zero word ending in a framing fault
	always_comb begin
		cmd_next = cmd_reg;
		case (cmd_reg)
			URXF_C_WAIT_BRK1: begin
				if (brk)
					cmd_next = URXF_C_WAIT_FE;
			end
			URXF_C_WAIT_FE: begin
				if (frame_bad)
					cmd_next = (shift_reg == 9'h000) ? URXF_C_WAIT_FE : URXF_C_WAIT_BRK1;
				else if (frame_good)
					cmd_next = (shift_reg[7:0] == CMD_ENABLE) ? URXF_C_WAIT_BRK2
						: URXF_C_WAIT_BRK1;
			end
			URXF_C_WAIT_BRK2: begin
				if (frame_bad)
					cmd_next = (shift_reg == 9'h000) ? URXF_C_WAIT_CMD : URXF_C_WAIT_BRK1;
				else if (frame_good)
					cmd_next = URXF_C_WAIT_BRK1;
			end
			URXF_C_WAIT_CMD: begin
				if (frame_good)
					cmd_next = URXF_C_WAIT_BRK1;
				else if (frame_bad)
					cmd_next = brk ? URXF_C_WAIT_CMD : URXF_C_WAIT_BRK1;
			end
			default: cmd_next = URXF_C_WAIT_BRK1;
		endcase
	end

	wire logic cmd_hit = (cmd_reg == URXF_C_WAIT_CMD) && frame_good;

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			cmd_reg <= URXF_C_WAIT_BRK1;
			por_reg <= 1'b0;
			prog_reg <= 1'b0;
		end else begin
			cmd_reg <= cmd_next;
			// Fixed codes, not programmable, so firmware cannot remap them
			por_reg <= cmd_hit && shift_reg[7:0] == CMD_SOFT_POR;
			prog_reg <= cmd_hit && shift_reg[7:0] == CMD_PROGRAM;
		end
	end
endmodule

// ===== tb/urxf_rx_asserts.sv
// Port checks for the receive block.
// Assumes one clock and async active-low reset.
`timescale 1ns/1ps
module urxf_rx_asserts (
	input wire logic i_mclk, // clk
	input wire logic i_nrst, // rst
	input wire logic i_multidrop_enable, // md
	input wire logic i_framing_flag_select, // sel
	input wire logic i_shared_wr, // wr
	input wire logic i_shared_wdata, // wd
	input wire logic [7:0] i_station_address, // adr
	input wire logic [7:0] i_station_address_mask, // msk
	input wire logic i_receive_irq_mask, // rm
	input wire logic i_rx_done_clr, // rc
	input wire logic i_tx_done_set, // ts
	input wire logic o_shared_rdata, // rd
	input wire logic o_mode_select_low, // ml
	input wire logic o_framing_fault_flag, // ff
	input wire logic [7:0] o_rx_data, // dat
	input wire logic o_rx_bit9, // b9
	input wire logic o_receive_done_flag, // rdf
	input wire logic o_transmit_done_flag, // tdf
	input wire logic o_receive_irq_pending, // rp
	input wire logic o_transmit_irq_pending, // tp
	input wire logic o_irq, // irq
	input wire logic o_soft_por, // por
	input wire logic o_program_req // prg
);
	wire logic [7:0] bc = i_station_address | i_station_address_mask;
	wire logic hit = ((((o_rx_data ^ i_station_address) & i_station_address_mask) == 8'h00)
		|| (((o_rx_data ^ bc) & bc) == 8'h00));
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	sequence s_fault_kept;
		o_framing_fault_flag && !(i_shared_wr && i_framing_flag_select && !i_shared_wdata);
	endsequence
	sequence s_md_load;
		i_multidrop_enable && $rose(o_receive_done_flag);
	endsequence
	a_rx_pend_and: assert property (o_receive_irq_pending == (o_receive_done_flag && i_receive_irq_mask))
		else $error("rx pending wrong");
	a_irq_merge: assert property (o_irq == (o_receive_irq_pending || o_transmit_irq_pending))
		else $error("irq wrong");
	a_shared_mux: assert property (o_shared_rdata == (i_framing_flag_select ? o_framing_fault_flag : o_mode_select_low))
		else $error("shared bit wrong");
	a_fault_sticky: assert property (s_fault_kept |=> o_framing_fault_flag)
		else $error("fault lost");
	a_tx_set_flag: assert property (i_tx_done_set |=> o_transmit_done_flag)
		else $error("tx flag not set");
	a_md_match_only: assert property (s_md_load |-> o_rx_bit9 && hit)
		else $error("multidrop load wrong");
	a_data_held: assert property (o_receive_done_flag && !i_rx_done_clr |=> $stable(o_rx_data))
		else $error("data overwritten");
	a_cmd_one_pulse: assert property (o_soft_por || o_program_req |=> !o_soft_por && !o_program_req)
		else $error("command pulse long");
endmodule
bind urxf_rx urxf_rx_asserts urxf_rx_asserts_i (.i_mclk, .i_nrst, .i_multidrop_enable,
	.i_framing_flag_select, .i_shared_wr, .i_shared_wdata, .i_station_address,
	.i_station_address_mask, .i_receive_irq_mask, .i_rx_done_clr, .i_tx_done_set,
	.o_shared_rdata, .o_mode_select_low, .o_framing_fault_flag, .o_rx_data, .o_rx_bit9,
	.o_receive_done_flag, .o_transmit_done_flag, .o_receive_irq_pending,
	.o_transmit_irq_pending, .o_irq, .o_soft_por, .o_program_req);

// ===== tb/urxf_host.sv
// Host serial model: nine-bit frames and breaks.
// Assumes the bench's 16x tick; line idles high.
`timescale 1ns/1ps
module urxf_host (
	input wire logic i_mclk, // clk
	input wire logic i_baud16, // tick
	output logic o_rxd // line
);
	initial o_rxd = 1'b1;
	task automatic send(input logic [8:0] w, input logic stp);
		logic [11:0] f;
		f = {1'b1, stp, w, 1'b0}; // Break: all zero, stop low
		for (int i = 0; i < 12; i++) begin
			@(negedge i_mclk);
			o_rxd = f[i];
			repeat (16) @(posedge i_mclk iff i_baud16);
		end
		// Hand back on a falling edge so callers drive off the sampling edge
		@(negedge i_mclk);
	endtask
endmodule

// ===== tb/tb_urxf_rx.sv
// Bench for the receive block with a host model.
// Assumes the package constants.
`timescale 1ns/1ps
module tb_urxf_rx;
	import urxf_pkg::*;
	logic i_mclk = 0, i_nrst = 0, i_baud16 = 0, i_rx_enable = 0, i_mode_high = 0;
	logic i_multidrop_enable = 0, i_framing_flag_select = 0, i_shared_wr = 0;
	logic i_shared_wdata = 0, i_receive_irq_mask = 0, i_transmit_irq_mask = 0;
	logic i_rx_done_clr = 0, i_tx_done_set = 0, i_tx_done_clr = 0;
	logic [7:0] i_station_address = 8'hF0, i_station_address_mask = 8'hFA;
	logic [1:0] bcnt = 2'h0;
	logic [3:0] por_n = 4'h0, prog_n = 4'h0;
	logic cnt_clr = 0;
	wire logic i_rxd, o_shared_rdata, o_mode_select_low, o_framing_fault_flag, o_rx_bit9;
	wire logic o_receive_done_flag, o_transmit_done_flag, o_receive_irq_pending;
	wire logic o_transmit_irq_pending, o_irq, o_soft_por, o_program_req;
	wire logic [7:0] o_rx_data;
	int num_errors = 0, cmp_count = 0;
	logic [9:0] md_tab [5] = '{10'h055, 10'h1F2, 10'h3F1, 10'h3F4, 10'h3FA};
	logic [9:0] cmd_tab [4] = '{10'h0FD, 10'h1FD, 10'h0FE, 10'h055};
	urxf_host urxf_host_i (.i_mclk, .i_baud16, .o_rxd(i_rxd));
	urxf_rx urxf_rx_i (.i_mclk, .i_nrst, .i_rxd, .i_baud16, .i_rx_enable, .i_mode_high,
		.i_multidrop_enable, .i_framing_flag_select, .i_shared_wr, .i_shared_wdata,
		.i_station_address, .i_station_address_mask, .i_receive_irq_mask,
		.i_transmit_irq_mask, .i_rx_done_clr, .i_tx_done_set, .i_tx_done_clr,
		.o_shared_rdata, .o_mode_select_low, .o_framing_fault_flag, .o_rx_data, .o_rx_bit9,
		.o_receive_done_flag, .o_transmit_done_flag, .o_receive_irq_pending,
		.o_transmit_irq_pending, .o_irq, .o_soft_por, .o_program_req);
	initial begin
		forever #5 i_mclk = ~i_mclk;
	end
	always @(negedge i_mclk) begin
		bcnt <= bcnt + 2'h1;
		i_baud16 <= (bcnt == 2'h3);
	end
	always @(posedge i_mclk) begin
		if (cnt_clr) begin
			por_n <= 4'h0;
			prog_n <= 4'h0;
		end else begin
			por_n <= por_n + {3'h0, o_soft_por};
			prog_n <= prog_n + {3'h0, o_program_req};
		end
	end
	task check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic pulse(ref logic s);
		@(negedge i_mclk);
		s = 1'b1;
		@(negedge i_mclk);
		s = 1'b0;
	endtask
	task summarize();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#400000;
		num_errors++;
		summarize();
	end
	initial begin
		repeat (2) @(negedge i_mclk);
		i_nrst = 1;
		i_rx_enable = 1;
		i_mode_high = 1;
		i_receive_irq_mask = 1;
		i_shared_wdata = 1;
		pulse(i_shared_wr);
		check("mode_low", o_mode_select_low, 1);
		urxf_host_i.send(9'h1A5, 1);
		check("word", {o_rx_bit9, o_rx_data}, 9'h1A5);
		check("rx_irq", {o_receive_irq_pending, o_irq}, 3);
		urxf_host_i.send(9'h03C, 1);
		check("kept", {o_rx_bit9, o_rx_data}, 9'h1A5);
		pulse(i_rx_done_clr);
		check("clr", {o_receive_done_flag, o_irq}, 0);
		i_shared_wdata = 0;
		pulse(i_shared_wr);
		urxf_host_i.send(9'h000, 0);
		check("fault", {o_framing_fault_flag, o_shared_rdata}, 2);
		pulse(i_rx_done_clr);
		urxf_host_i.send(9'h055, 1);
		check("mode2", o_rx_data, 8'h55);
		i_framing_flag_select = 1; // Select before fault access
		#1 check("sticky", {o_framing_fault_flag, o_shared_rdata}, 3);
		pulse(i_shared_wr);
		check("f_clr", {o_framing_fault_flag, o_mode_select_low}, 0);
		pulse(i_rx_done_clr);
		i_multidrop_enable = 1;
		foreach (md_tab[k]) begin
			urxf_host_i.send(md_tab[k][8:0], 1);
			check("md", o_receive_done_flag, md_tab[k][9]);
			pulse(i_rx_done_clr);
		end
		i_multidrop_enable = 0;
		foreach (cmd_tab[k]) begin
			pulse(cnt_clr);
			urxf_host_i.send(9'h000, 0);
			urxf_host_i.send({1'b0, CMD_ENABLE}, 1); // Only inside the sequence
			if (cmd_tab[k][8]) urxf_host_i.send(9'h011, 1);
			urxf_host_i.send(9'h000, 0);
			urxf_host_i.send({1'b0, cmd_tab[k][7:0]}, 1);
			check("cmd", {por_n, prog_n}, {cmd_tab[k] == 10'h0FE, 3'h0, cmd_tab[k] == 10'h0FD});
		end
		pulse(i_rx_done_clr);
		pulse(i_tx_done_set);
		check("tx_m0", {o_transmit_done_flag, o_transmit_irq_pending}, 2);
		i_transmit_irq_mask = 1;
		#1 check("tx_m1", {o_transmit_irq_pending, o_irq}, 3);
		pulse(i_tx_done_clr);
		check("tx_clr", {o_transmit_done_flag, o_irq}, 0);
		urxf_host_i.send(9'h000, 0);
		check("f_set", o_framing_fault_flag, 1);
		i_nrst = 0;
		@(negedge i_mclk);
		i_nrst = 1;
		check("f_rst", {o_framing_fault_flag, o_receive_done_flag}, 0);
		summarize();
	end
endmodule
